/* pdc_map.vh */
/*
  Register map, field layout, reset values and widths of the port data and
  pull-up control block.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef PDC_MAP_VH
`define PDC_MAP_VH

// Register indices as printed; the byte address is four times the index
`define PDC_IDX_OUTPUT_LATCH   32'hFFFE3982
`define PDC_IDX_PIN_LEVELS     32'hFFFE399E
`define PDC_IDX_PULLUP_ENABLE  32'hFFFE3990

// Index bits that the decoder compares (index bits [9:0])
`define PDC_IDX_DEC_MSB        9
`define PDC_IDX_DEC_LSB        0

// APB address bits that carry those index bits
`define PDC_ADDR_DEC_MSB       11
`define PDC_ADDR_DEC_LSB       2

// Port geometry
`define PDC_PORT_WIDTH         16
`define PDC_PULLUP_WIDTH       3
`define PDC_BYTE_WIDTH         8

// Reset values
`define PDC_LATCH_RESET        16'h0000
`define PDC_PULLUP_RESET       3'h0
`define PDC_PIN_RESET          16'h0000

// Writable bits of the pull-up register (bits 2..0 only)
`define PDC_PULLUP_WMASK       16'h0007

// Bus word width and strobe width
`define PDC_DATA_WIDTH         32
`define PDC_STRB_WIDTH         4
`define PDC_WORD_ZERO          32'h00000000

`endif

/* pdc_sync.v */
/*
  Two-stage synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is independent; no word coherence across bits is promised.
*/
`timescale 1ns/10ps
module pdc_sync
#(
    parameter WIDTH = 16
)
(
    // Clock and reset
    input  wire             sys_clk,
    input  wire             reset,
    input  wire             ce,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // First stage feeds only the second stage, to contain metastability
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else if (ce)
        begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

/* pdc_reg16.v */
/*
  One 16-bit software register with byte-lane writes and a writable-bit mask.
  Assumes the write pulse lasts one cycle and strobes are sampled with it.
*/
`timescale 1ns/10ps
`include "pdc_map.vh"
module pdc_reg16
#(
    parameter [15:0] RESET_VALUE = 16'h0000,
    parameter [15:0] WRITE_MASK  = 16'hFFFF
)
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        ce,
    // Write port
    input  wire        wr_en,
    input  wire [1:0]  byte_en,
    input  wire [15:0] wr_data,
    // Stored value
    output reg  [15:0] q
);

    wire [15:0] lane_mask;
    wire [15:0] next_q;

    // Masked bits never store, so reserved bits stay at their reset value
    assign lane_mask = {{`PDC_BYTE_WIDTH{byte_en[1]}}, {`PDC_BYTE_WIDTH{byte_en[0]}}} & WRITE_MASK;
    assign next_q    = (q & ~lane_mask) | (wr_data & lane_mask);

    // Update on the completing bus cycle only
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            q <= RESET_VALUE;
        else if (ce && wr_en)
            q <= next_q;
    end

endmodule

/* pdc_port_top.v */
/*
  Port D data and pin-level registers and port A upper pull-up control,
  reached over an APB slave with one wait state.
  Assumes the pin-function logic outside supplies a per-pin general-output
  select on sys_clk, and the pad ring resolves pin_out with pin_oe.
*/
// Decided for this implementation: register access over APB.
// What this block does
// - Pull-up on pins A18, A17, A16 follows enable bits 2, 1, 0.
// - Pull-up register bits 15 to 3 read zero; software writes zero there.
// - A general-output pin is driven with its written data bit.
// - A general-output pin reads back the stored latch bit.
// - A general-input pin reads back the sampled pin level.
// - Writes to a general-input pin store but leave the pin undriven.
// - Data register is 16-bit read/write, bit n is pin n, resets zero.
// - Pin-level register is read-only; byte and halfword accesses are accepted.
`timescale 1ns/10ps
`include "pdc_map.vh"
module pdc_port_top
#(
    parameter PORT_WIDTH = `PDC_PORT_WIDTH,
    parameter ADDR_WIDTH = 32
)
(
    // Clock, reset, clock enable
    input  wire                        sys_clk,
    input  wire                        reset,
    input  wire                        ce,
    // APB slave
    input  wire                        psel,
    input  wire                        penable,
    input  wire                        pwrite,
    input  wire [ADDR_WIDTH-1:0]       paddr,
    input  wire [`PDC_DATA_WIDTH-1:0]  pwdata,
    input  wire [`PDC_STRB_WIDTH-1:0]  pstrb,
    output reg  [`PDC_DATA_WIDTH-1:0]  prdata,
    output reg                         pready,
    output reg                         pslverr,
    // Pin function from the multiplexer: 1 = general output, 0 = general input
    input  wire [PORT_WIDTH-1:0]       gpo_select,
    // Port D pins
    input  wire [PORT_WIDTH-1:0]       pin_in,
    output reg  [PORT_WIDTH-1:0]       pin_out,
    output reg  [PORT_WIDTH-1:0]       pin_oe,
    // Port A upper pull-up enables, bit 2 = A18, bit 1 = A17, bit 0 = A16
    output reg  [`PDC_PULLUP_WIDTH-1:0] pullup_on
);

    // Full printed indices; only the decoded low bits are kept on purpose
    localparam [31:0] IDX_LATCH_FULL  = `PDC_IDX_OUTPUT_LATCH;
    localparam [31:0] IDX_LEVELS_FULL = `PDC_IDX_PIN_LEVELS;
    localparam [31:0] IDX_PULLUP_FULL = `PDC_IDX_PULLUP_ENABLE;
    localparam [9:0]  IDX_LATCH       = IDX_LATCH_FULL[`PDC_IDX_DEC_MSB:`PDC_IDX_DEC_LSB];
    localparam [9:0]  IDX_LEVELS      = IDX_LEVELS_FULL[`PDC_IDX_DEC_MSB:`PDC_IDX_DEC_LSB];
    localparam [9:0]  IDX_PULLUP      = IDX_PULLUP_FULL[`PDC_IDX_DEC_MSB:`PDC_IDX_DEC_LSB];

    wire [9:0]            addr_idx;
    wire                  hit_latch;
    wire                  hit_levels;
    wire                  hit_pullup;
    wire                  hit_any;
    wire                  access_wait;
    wire                  access_done;
    wire                  wr_latch;
    wire                  wr_pullup;
    wire [15:0]           latch_q;
    wire [15:0]           pullup_q;
    wire [PORT_WIDTH-1:0] pin_sync;
    reg  [15:0]           data_view;
    reg  [`PDC_DATA_WIDTH-1:0] next_prdata;
    integer               i;

    // Decode on the low index bits only; the block sits in a 4 KB window
    assign addr_idx   = paddr[`PDC_ADDR_DEC_MSB:`PDC_ADDR_DEC_LSB];
    assign hit_latch  = (addr_idx == IDX_LATCH);
    assign hit_levels = (addr_idx == IDX_LEVELS);
    assign hit_pullup = (addr_idx == IDX_PULLUP);
    assign hit_any    = hit_latch | hit_levels | hit_pullup;

    // First access cycle prepares the answer, the second completes it
    assign access_wait = psel & penable & ~pready;
    assign access_done = psel & penable & pready;

    // Writes land only at the completing edge; pin-level writes go nowhere
    assign wr_latch  = access_done & pwrite & hit_latch;
    assign wr_pullup = access_done & pwrite & hit_pullup;

    // Pin levels arrive from outside the clock domain
    pdc_sync #(
        .WIDTH (PORT_WIDTH)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .ce       (ce),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Output latch: all sixteen bits writable, byte lanes honoured
    pdc_reg16 #(
        .RESET_VALUE (`PDC_LATCH_RESET),
        .WRITE_MASK  (16'hFFFF)
    ) u_latch (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ce      (ce),
        .wr_en   (wr_latch),
        .byte_en (pstrb[1:0]),
        .wr_data (pwdata[15:0]),
        .q       (latch_q)
    );

    // Pull-up enables: only bits 2..0 store, upper bits stay zero
    pdc_reg16 #(
        .RESET_VALUE ({13'h0000, `PDC_PULLUP_RESET}),
        .WRITE_MASK  (`PDC_PULLUP_WMASK)
    ) u_pullup (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ce      (ce),
        .wr_en   (wr_pullup),
        .byte_en (pstrb[1:0]),
        .wr_data (pwdata[15:0]),
        .q       (pullup_q)
    );

    // Per-pin read view: outputs read the latch, inputs read the pin
    always @*
    begin
        data_view = 16'h0000;
        for (i = 0; i < PORT_WIDTH; i = i + 1)
        begin
            if (gpo_select[i])
                data_view[i] = latch_q[i];
            else
                data_view[i] = pin_sync[i];
        end
    end

    // Read mux; narrow registers sit in the low bits, the rest reads zero
    always @*
    begin
        next_prdata = `PDC_WORD_ZERO;
        if (!pwrite)
        begin
            if (hit_latch)
                next_prdata[15:0] = data_view;
            else if (hit_levels)
                next_prdata[PORT_WIDTH-1:0] = pin_sync;
            else if (hit_pullup)
                next_prdata[15:0] = pullup_q;
        end
    end

    // Bus answer: registered, one wait state, error on unmapped address
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            prdata  <= `PDC_WORD_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            if (access_wait)
            begin
                pready  <= 1'b1;
                pslverr <= ~hit_any;
                prdata  <= next_prdata;
            end
            else
            begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
                prdata  <= `PDC_WORD_ZERO;
            end
        end
    end

    // Pad drive: only general-output pins are enabled, so a stored write
    // on an input pin has no effect on the wire
    always @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_out   <= `PDC_PIN_RESET;
            pin_oe    <= `PDC_PIN_RESET;
            pullup_on <= `PDC_PULLUP_RESET;
        end
        else if (ce)
        begin
            pin_out   <= latch_q[PORT_WIDTH-1:0];
            pin_oe    <= gpo_select;
            pullup_on <= pullup_q[`PDC_PULLUP_WIDTH-1:0];
        end
    end

endmodule

/* pdc_props_properties.sv */
/* Checker for the port block. Assumes one wait state and ce held high. */
`timescale 1ns/10ps
module pdc_props (
    input wire        sys_clk, reset, ce, psel, penable, pwrite, pready, pslverr,
    input wire [31:0] paddr, pwdata, prdata,
    input wire [3:0]  pstrb,
    input wire [15:0] gpo_select, pin_out, pin_oe,
    input wire [2:0]  pullup_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Completed transfer and the decoded index
    wire [9:0] ix   = paddr[11:2];
    wire       done = psel && penable && pready && ce;
    wire       hit  = ix == 10'h182 || ix == 10'h19E || ix == 10'h190;
    sequence setup_then_access;
        psel && !penable && ce ##1 psel && penable && ce;
    endsequence
    pull_load_a: assert property (done && pwrite && ix == 10'h190 && pstrb[0] |-> ##2 pullup_on == $past(pwdata[2:0], 2))
        else $error("pull-up enables wrong");
    pull_zero_a: assert property (done && !pwrite && ix == 10'h190 |-> prdata[31:3] == 0)
        else $error("pull-up upper bits set");
    latch_drive_a: assert property (done && pwrite && ix == 10'h182 && pstrb[1:0] == 2'b11
        |-> ##2 pin_out == $past(pwdata[15:0], 2)) else $error("pin data wrong");
    out_read_a: assert property (done && !pwrite && ix == 10'h182
        |-> ((prdata[15:0] ^ $past(pin_out)) & $past(gpo_select)) == 0) else $error("output readback");
    drive_en_a: assert property (ce |=> pin_oe == $past(gpo_select)) else $error("drive enable wrong");
    one_wait_a: assert property (setup_then_access |-> !pready ##1 pready) else $error("wait state wrong");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
    bad_addr_a: assert property (done && !hit |-> pslverr && prdata == 0) else $error("unmapped");
    good_addr_a: assert property (done && hit |-> !pslverr) else $error("mapped error");
endmodule
bind pdc_port_top pdc_props i_pdc_props (.sys_clk(sys_clk), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pstrb(pstrb), .gpo_select(gpo_select), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on));

/* pdc_board.sv */
/* Board model on the port D pins. Assumes outside levels come from the bench. */
`timescale 1ns/10ps
module pdc_board (
    input wire [15:0]  pin_out, pin_oe, ext_level,
    output wire [15:0] pin_level
);
    // An enabled pin shows its driver, otherwise the board level
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* port_data_and_pullup_control_bench.sv */
/* Self-checking bench of the port block. Assumes the board model and checker. */
`timescale 1ns/10ps
module port_data_and_pullup_control_bench;
    reg         sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er, ce = 1;
    reg [31:0]  paddr = 0, pwdata = 0, rd;
    reg [3:0]   pstrb = 0;
    reg [15:0]  gpo_select = 16'hFFFF, ext_level = 0;
    wire [31:0] prdata;
    wire        pready, pslverr;
    wire [15:0] pin_out, pin_oe, pin_level;
    wire [2:0]  pullup_on;
    integer     n_errors = 0, total_checks = 0, cyc = 0;
    localparam [31:0] LATCH = 32'h608, LEVELS = 32'h678, PULL = 32'h640;
    pdc_port_top i_pdc_port_top (.sys_clk(sys_clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpo_select(gpo_select), .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on));
    pdc_board i_pdc_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_level(pin_level));
    initial forever #2.5 sys_clk = ~sys_clk;
    // A hang is cut short well beyond the hundred or so cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    task chk(input string what, input [31:0] exp, got);
        begin
            total_checks = total_checks + 1;
            if (exp !== got)
            begin
                n_errors = n_errors + 1;
                $display("[FAIL] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // One APB transfer; the request stands until pready is sampled high
    task apb(input w, input [31:0] a, d, input [3:0] s);
        begin
            @(posedge sys_clk);
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
            @(posedge sys_clk);
            penable <= 1;
            @(posedge sys_clk);
            while (pready !== 1'b1) @(posedge sys_clk);
            rd = prdata;
            er = pslverr;
            psel <= 0; penable <= 0;
        end
    endtask
    task t_reset;
        begin
            apb(0, LATCH, 0, 0); chk("latch", 0, rd);
            apb(0, PULL, 0, 0); chk("pullup reg", 0, rd);
            chk("pullup_on", 0, pullup_on);
            apb(0, 32'h700, 0, 0); chk("pslverr", 1, er);
        end
    endtask
    task t_output;
        begin
            ext_level <= 16'h0F0F;
            apb(1, LATCH, 32'hFFFFA5C3, 4'h3);
            repeat (3) @(posedge sys_clk);
            chk("pins", 16'hA5C3, pin_level);
            apb(0, LATCH, 0, 0); chk("latch", 32'hA5C3, rd);
            apb(1, LATCH, 32'h7E, 4'h1); apb(0, LATCH, 0, 0); chk("byte write", 32'hA57E, rd);
        end
    endtask
    task t_input;
        begin
            gpo_select <= 0; ext_level <= 16'h3C96;
            apb(1, LATCH, 32'h1234, 4'h3);
            repeat (4) @(posedge sys_clk);
            chk("pins", 16'h3C96, pin_level);
            apb(0, LATCH, 0, 0); chk("input read", 32'h3C96, rd);
            apb(1, LEVELS, 32'hFFFF, 4'h3); apb(0, LEVELS, 0, 0); chk("levels", 32'h3C96, rd);
            gpo_select <= 16'hFFFF;
            repeat (4) @(posedge sys_clk);
            apb(0, LATCH, 0, 0); chk("stored", 32'h1234, rd);
        end
    endtask
    task t_pull;
        begin
            apb(1, PULL, 32'hFFFF, 4'h3); repeat (2) @(posedge sys_clk); chk("pullup_on", 3'h7, pullup_on);
            apb(0, PULL, 0, 0); chk("pullup reg", 32'h7, rd);
            apb(1, PULL, 32'h2, 4'h1); repeat (2) @(posedge sys_clk); chk("pullup_on", 3'h2, pullup_on);
        end
    endtask
    // Clock enable low must freeze the pad drive state
    task t_freeze;
        begin
            @(posedge sys_clk);
            ce <= 0; gpo_select <= 0;
            repeat (3) @(posedge sys_clk);
            chk("frozen oe", 16'hFFFF, pin_oe);
            ce <= 1;
            repeat (2) @(posedge sys_clk);
            chk("thawed oe", 16'h0000, pin_oe);
            gpo_select <= 16'hFFFF;
            repeat (2) @(posedge sys_clk);
        end
    endtask
    task test_done;
        begin
            if (n_errors == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset <= 0;
        t_reset;
        t_output;
        t_input;
        t_pull;
        t_freeze;
        test_done;
    end
endmodule
